// ### hdl/edrs_dma_mover.sv
// Byte mover answering the device's transmit and receive DMA requests
`timescale 1ns/10ps
module edrs_dma_mover (
	input  wire logic       mclk,
	input  wire logic       reset_n,
	input  wire logic       tx_dreq,
	input  wire logic       rx_dreq,
	output logic            tx_dack_n,
	output logic            rx_dack_n,
	input  wire logic [7:0] dma_d_in,
	output logic [7:0]      dma_d_out,
	output logic            dma_d_oe,
	input  wire logic       ld_tx,
	input  wire logic [7:0] tx_base,
	input  wire logic       ld_rx,
	input  wire logic [7:0] rx_base,
	output logic [7:0]      mem_addr,
	input  wire logic [7:0] mem_rdata,
	output logic            mem_we,
	output logic [7:0]      mem_wdata
);
	import edrs_pkg::*;

	edrs_mv_state_t state_reg;
	logic           dir_rx_reg;
	logic [7:0]     tx_ptr_reg;
	logic [7:0]     rx_ptr_reg;

	// Pointer selection: in idle a pending transmit request wins
	wire sel_rx   = (state_reg == MV_IDLE) ? !tx_dreq : dir_rx_reg;
	wire dreq_cur = dir_rx_reg ? rx_dreq : tx_dreq;
	assign mem_addr  = sel_rx ? rx_ptr_reg : tx_ptr_reg;
	assign mem_we    = (state_reg == MV_CYC) && dir_rx_reg;
	assign mem_wdata = dma_d_in;

	// One byte per acknowledge, repeated while request stands
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_reg  <= MV_IDLE;
			dir_rx_reg <= 1'b0;
			tx_dack_n  <= 1'b1;
			rx_dack_n  <= 1'b1;
			dma_d_out  <= 8'h00;
			dma_d_oe   <= 1'b0;
		end else begin
			case (state_reg)
				MV_IDLE: begin
					if (tx_dreq) begin
						dir_rx_reg <= 1'b0;
						tx_dack_n  <= 1'b0;
						dma_d_out  <= mem_rdata;
						dma_d_oe   <= 1'b1;
						state_reg  <= MV_CYC;
					end else if (rx_dreq) begin
						dir_rx_reg <= 1'b1;
						rx_dack_n  <= 1'b0;
						state_reg  <= MV_CYC;
					end
				end
				MV_CYC: begin
					tx_dack_n <= 1'b1;
					rx_dack_n <= 1'b1;
					dma_d_oe  <= 1'b0;
					state_reg <= MV_GAP;
				end
				MV_GAP: begin
					if (dreq_cur) begin
						tx_dack_n <= dir_rx_reg;
						rx_dack_n <= !dir_rx_reg;
						dma_d_out <= mem_rdata;
						dma_d_oe  <= !dir_rx_reg;
						state_reg <= MV_CYC;
					end else begin
						state_reg <= MV_IDLE;
					end
				end
				default: state_reg <= MV_IDLE;
			endcase
		end
	end

	// Buffer pointers: a base load overrides the byte step
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			tx_ptr_reg <= 8'h00;
			rx_ptr_reg <= 8'h00;
		end else begin
			if (ld_tx)
				tx_ptr_reg <= tx_base;
			else if (state_reg == MV_CYC && !dir_rx_reg)
				tx_ptr_reg <= tx_ptr_reg + 8'h01;
			if (ld_rx)
				rx_ptr_reg <= rx_base;
			else if (state_reg == MV_CYC && dir_rx_reg)
				rx_ptr_reg <= rx_ptr_reg + 8'h01;
		end
	end

endmodule

// ### hdl/edrs_host.sv
// Host-side controller: software registers, device command sequencer, DMA buffer memory
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
module edrs_host (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic [2:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	output logic [7:0]       dev_addr,
	output logic             dev_cs_n,
	output logic             dev_rd_n,
	output logic             dev_wr_n,
	input  wire logic [7:0]  dev_d_in,
	output logic [7:0]       dev_d_out,
	output logic             dev_d_oe,
	input  wire logic        dev_irq_n,
	input  wire logic        tx_dreq,
	input  wire logic        rx_dreq,
	output logic             tx_dack_n,
	output logic             rx_dack_n,
	input  wire logic [7:0]  dma_d_in,
	output logic [7:0]       dma_d_out,
	output logic             dma_d_oe
);
	import edrs_pkg::*;

	// ************************************************************
	// Declarations
	// ************************************************************
	logic [7:0]    mem [0:255];
	logic [11:0]   tx_len_reg;
	logic [11:0]   rx_max_reg;
	logic [11:0]   rx_lim_reg;
	logic [7:0]    tx_base_reg;
	logic [7:0]    rx_base_reg;
	logic [7:0]    rx_base2_reg;
	logic [3:0]    status_reg;
	logic [3:0]    status_next;
	logic [11:0]   rx_cnt_reg;
	logic          tx_pend_reg;
	logic          eop_reg;
	logic          info_reg;
	logic          arm_pend_reg;
	logic          dis_reg;
	logic [7:0]    mem_sel_reg;
	logic          wait_reg;
	logic [7:0]    isr_reg;
	logic          issued_reg;
	edrs_state_t   state_reg;
	edrs_state_t   step_nxt;
	edrs_state_t   evt_nxt;
	edrs_acc_req_t acc_req;
	logic          acc_done;
	logic [7:0]    acc_rdata;
	logic [7:0]    mv_addr;
	logic          mv_we;
	logic [7:0]    mv_wdata;
	logic [31:0]   rd_word;

	// ************************************************************
	// Avalon decode
	// ************************************************************
	// Memory write lands at the edge that ends the wait cycle, never beside a mover write
	wire mem_hold  = (avs_address == SR_MEM) && mv_we;
	wire wr_commit = avs_write && !wait_reg;
	wire wr_ctrl   = wr_commit && (avs_address == SR_CTRL);
	wire wr_stat   = wr_commit && (avs_address == SR_STAT);
	wire wr_mem    = avs_write && wait_reg && !mem_hold && (avs_address == SR_MEM);
	wire busy      = (state_reg != ST_IDLE) || tx_pend_reg || arm_pend_reg;

	// Readback selection; unused bits of each word read zero
	always_comb begin
		case (avs_address)
			SR_CTRL:  rd_word = {23'h0, busy, 3'h0, dis_reg, arm_pend_reg,
			                     info_reg, eop_reg, tx_pend_reg};
			SR_TXLEN: rd_word = {20'h0, tx_len_reg};
			SR_RXMAX: rd_word = {20'h0, rx_max_reg};
			SR_RXLIM: rd_word = {20'h0, rx_lim_reg};
			SR_BASE:  rd_word = {8'h0, rx_base2_reg, rx_base_reg, tx_base_reg};
			SR_STAT:  rd_word = {28'h0, status_reg};
			SR_RXCNT: rd_word = {20'h0, rx_cnt_reg};
			SR_MEM:   rd_word = {16'h0, mem_sel_reg, mem[mem_sel_reg]};
			default:  rd_word = 32'h0000_0000;
		endcase
	end

	// One wait cycle per access, more for the memory word while the mover writes; read data latched with its release
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			wait_reg     <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			wait_reg <= !(wait_reg && (avs_read || avs_write) && !mem_hold);
			if (wait_reg && avs_read)
				avs_readdata <= rd_word;
		end
	end
	assign avs_waitrequest = wait_reg;

	// ************************************************************
	// Software registers
	// ************************************************************
	wire tx_take  = (state_reg == ST_IDLE) && dev_irq_n && tx_pend_reg;
	wire arm_take = (state_reg == ST_IDLE) && dev_irq_n && !tx_pend_reg && arm_pend_reg;
	wire step_ok  = issued_reg && acc_done;

	// Configuration words written by software
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			tx_len_reg   <= 12'h000;
			rx_max_reg   <= 12'h000;
			rx_lim_reg   <= 12'h000;
			tx_base_reg  <= 8'h00;
			rx_base_reg  <= 8'h00;
			rx_base2_reg <= 8'h00;
			eop_reg      <= 1'b0;
			info_reg     <= 1'b0;
			dis_reg      <= 1'b0;
			mem_sel_reg  <= 8'h00;
		end else begin
			if (wr_commit && avs_address == SR_TXLEN)
				tx_len_reg <= avs_writedata[11:0];
			if (wr_commit && avs_address == SR_RXMAX)
				rx_max_reg <= avs_writedata[11:0];
			if (wr_commit && avs_address == SR_RXLIM)
				rx_lim_reg <= avs_writedata[11:0];
			if (wr_commit && avs_address == SR_BASE) begin
				tx_base_reg  <= avs_writedata[7:0];
				rx_base_reg  <= avs_writedata[15:8];
				rx_base2_reg <= avs_writedata[23:16];
			end
			if (wr_ctrl) begin
				eop_reg  <= avs_writedata[C_EOP];
				info_reg <= avs_writedata[C_INFO];
				dis_reg  <= avs_writedata[C_DIS];
			end
			if (wr_mem)
				mem_sel_reg <= avs_writedata[15:8];
		end
	end

	// Commands and events: a new set wins over a same-cycle clear
	always_comb begin
		status_next = status_reg & ~(wr_stat ? avs_writedata[3:0] : 4'h0);
		if (state_reg == ST_EVT)
			status_next = status_next | {1'b0, isr_reg[EV_RBF],
			                             isr_reg[EV_TX_ALL_SENT_FLAG], isr_reg[EV_TXDONE]};
		if (state_reg == ST_RCH && step_ok)
			status_next[EV_RDONE] = 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			status_reg   <= 4'h0;
			tx_pend_reg  <= 1'b0;
			arm_pend_reg <= 1'b0;
		end else begin
			status_reg   <= status_next;
			tx_pend_reg  <= (tx_pend_reg && !tx_take) || (wr_ctrl && avs_writedata[C_TXGO]);
			arm_pend_reg <= (arm_pend_reg && !arm_take) || (wr_ctrl && avs_writedata[C_ARM]);
		end
	end

	// ************************************************************
	// Device command sequencer
	// ************************************************************
	// Access and successor for each stepping state
	always_comb begin
		acc_req  = '{wr: 1'b1, addr: OFS_ISR, data: 8'h00};
		step_nxt = ST_IDLE;
		case (state_reg)
			ST_TXL: begin
				acc_req  = '{wr: 1'b1, addr: OFS_TXBCL, data: tx_len_reg[7:0]};
				step_nxt = ST_TXH;
			end
			ST_TXH: begin
				// Start (or info frame start), with or without end of packet
				acc_req.addr            = OFS_TXBCH;
				acc_req.data            = {4'h0, tx_len_reg[11:8]};
				acc_req.data[TXH_START] = !info_reg;
				acc_req.data[TXH_INFO]  = info_reg;
				acc_req.data[TXH_EOP]   = eop_reg;
			end
			ST_ISR: begin
				acc_req.wr = 1'b0;
				step_nxt   = ST_EVT;
			end
			ST_RCL: begin
				acc_req  = '{wr: 1'b0, addr: OFS_RX_BYTE_COUNT_LOW, data: 8'h00};
				step_nxt = ST_RCH;
			end
			ST_RCH: begin
				acc_req = '{wr: 1'b0, addr: OFS_RX_BYTE_COUNT_HIGH, data: 8'h00};
			end
			ST_RLL: begin
				acc_req  = '{wr: 1'b1, addr: OFS_RLLL, data: rx_lim_reg[7:0]};
				step_nxt = ST_RLH;
			end
			ST_RLH: begin
				acc_req  = '{wr: 1'b1, addr: OFS_RLLH, data: {4'h0, rx_lim_reg[11:8]}};
				step_nxt = ST_RML;
			end
			ST_RML: begin
				acc_req  = '{wr: 1'b1, addr: OFS_RMBL, data: rx_max_reg[7:0]};
				step_nxt = ST_RMH;
			end
			ST_RMH, ST_RRA: begin
				// Size high byte, limit disable and arm in one write
				acc_req.addr          = OFS_RMBH;
				acc_req.data          = {4'h0, rx_max_reg[11:8]};
				acc_req.data[RMH_ARM] = 1'b1;
				acc_req.data[RMH_DIS] = dis_reg;
			end
			default: begin
				step_nxt = ST_IDLE;
			end
		endcase
	end

	// Buffer full re-arms at once; receive done waits for software
	assign evt_nxt = isr_reg[EV_RBF] ? ST_RRA :
	                 (isr_reg[EV_RDONE] ? ST_RCL : ST_IDLE);
	wire step_st   = (state_reg != ST_IDLE) && (state_reg != ST_EVT);
	wire acc_go    = step_st && !issued_reg;
	wire ld_rx     = arm_take || ((state_reg == ST_EVT) && isr_reg[EV_RBF]);

	// Interrupt service first, then transmit, then receive arm
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_reg  <= ST_IDLE;
			issued_reg <= 1'b0;
		end else if (state_reg == ST_IDLE) begin
			if (!dev_irq_n)
				state_reg <= ST_ISR;
			else if (tx_pend_reg)
				state_reg <= ST_TXL;
			else if (arm_pend_reg)
				state_reg <= ST_RLL;
		end else if (state_reg == ST_EVT) begin
			state_reg <= evt_nxt;
		end else if (acc_go) begin
			issued_reg <= 1'b1;
		end else if (step_ok) begin
			issued_reg <= 1'b0;
			state_reg  <= step_nxt;
		end
	end

	// Captured device answers
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			isr_reg    <= 8'h00;
			rx_cnt_reg <= 12'h000;
		end else if (step_ok) begin
			if (state_reg == ST_ISR)
				isr_reg <= acc_rdata;
			if (state_reg == ST_RCL)
				rx_cnt_reg[7:0] <= acc_rdata;
			if (state_reg == ST_RCH)
				rx_cnt_reg[11:8] <= acc_rdata[3:0];
		end
	end

	edrs_reg_access u_acc (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.go        (acc_go),
		.req       (acc_req),
		.dev_addr  (dev_addr),
		.dev_cs_n  (dev_cs_n),
		.dev_rd_n  (dev_rd_n),
		.dev_wr_n  (dev_wr_n),
		.dev_d_in  (dev_d_in),
		.dev_d_out (dev_d_out),
		.dev_d_oe  (dev_d_oe),
		.done      (acc_done),
		.rdata     (acc_rdata)
	);

	// ************************************************************
	// DMA buffer memory and mover
	// ************************************************************
	// Mover has the write port; software writes stall behind it
	always_ff @(posedge mclk) begin
		if (mv_we)
			mem[mv_addr] <= mv_wdata;
		else if (wr_mem)
			mem[avs_writedata[15:8]] <= avs_writedata[7:0];
	end

	edrs_dma_mover u_mv (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.tx_dreq   (tx_dreq),
		.rx_dreq   (rx_dreq),
		.tx_dack_n (tx_dack_n),
		.rx_dack_n (rx_dack_n),
		.dma_d_in  (dma_d_in),
		.dma_d_out (dma_d_out),
		.dma_d_oe  (dma_d_oe),
		.ld_tx     (tx_take),
		.tx_base   (tx_base_reg),
		.ld_rx     (ld_rx),
		.rx_base   (arm_take ? rx_base_reg : rx_base2_reg),
		.mem_addr  (mv_addr),
		.mem_rdata (mem[mv_addr]),
		.mem_we    (mv_we),
		.mem_wdata (mv_wdata)
	);

endmodule

// ### hdl/edrs_pkg.sv
// Constants, device register map and shared types for the DMA support controller
//
// Overview of operation
// - Host loads buffer address and transmit count
// - Start plus end-of-packet sends whole packet
// - Start without end-of-packet for partial buffers
// - Final buffer carries start with end-of-packet
// - Info frame start may replace start
// - After buffer full, reload base and re-arm
// - After receive done, read count, re-arm; the code reads the count and leaves re-arm to software
// - Host programs receive length limit
// - Each bus cycle moves one byte
// - Size write and arm in one access
package edrs_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int         CLK_MHZ   = 20;
	localparam int         T_ACC_NS  = 100;
	localparam int         ACC_CYC   = (T_ACC_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] ACC_LAST  = 4'(ACC_CYC - 1);

	// ************************************************************
	// Device register offsets
	// ************************************************************
	localparam logic [7:0] OFS_TXBCL = 8'h2A;
	localparam logic [7:0] OFS_TXBCH = 8'h2B;
	localparam logic [7:0] OFS_RMBL  = 8'h2C;
	localparam logic [7:0] OFS_RMBH  = 8'h2D;
	localparam logic [7:0] OFS_RX_BYTE_COUNT_LOW  = 8'h2E;
	localparam logic [7:0] OFS_RX_BYTE_COUNT_HIGH  = 8'h2F;
	localparam logic [7:0] OFS_RLLL  = 8'h30;
	localparam logic [7:0] OFS_RLLH  = 8'h31;
	localparam logic [7:0] OFS_ISR   = 8'h32;

	// ************************************************************
	// Device field positions
	// ************************************************************
	localparam int TXH_START = 7;
	localparam int TXH_EOP   = 6;
	localparam int TXH_INFO  = 5;
	localparam int RMH_ARM   = 7;
	localparam int RMH_DIS   = 6;
	localparam int EV_TXDONE = 0;
	localparam int EV_TX_ALL_SENT_FLAG   = 1;
	localparam int EV_RBF    = 2;
	localparam int EV_RDONE  = 3;

	// ************************************************************
	// Own register word indexes and control bits
	// ************************************************************
	localparam logic [2:0] SR_CTRL   = 3'h0;
	localparam logic [2:0] SR_TXLEN  = 3'h1;
	localparam logic [2:0] SR_RXMAX  = 3'h2;
	localparam logic [2:0] SR_RXLIM  = 3'h3;
	localparam logic [2:0] SR_BASE   = 3'h4;
	localparam logic [2:0] SR_STAT   = 3'h5;
	localparam logic [2:0] SR_RXCNT  = 3'h6;
	localparam logic [2:0] SR_MEM    = 3'h7;
	localparam int         C_TXGO    = 0;
	localparam int         C_EOP     = 1;
	localparam int         C_INFO    = 2;
	localparam int         C_ARM     = 3;
	localparam int         C_DIS     = 4;
	localparam int         C_BUSY    = 8;

	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] data;
	} edrs_acc_req_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0, ST_TXL = 4'h1, ST_TXH = 4'h3, ST_ISR = 4'h2,
		ST_EVT  = 4'h6, ST_RCL = 4'h7, ST_RCH = 4'h5, ST_RLL = 4'h4,
		ST_RLH  = 4'hC, ST_RML = 4'hD, ST_RMH = 4'hF, ST_RRA = 4'hE
	} edrs_state_t;

	typedef enum logic [1:0] {
		MV_IDLE = 2'h0, MV_CYC = 2'h1, MV_GAP = 2'h3
	} edrs_mv_state_t;

endpackage

// ### hdl/edrs_reg_access.sv
// Register access sequencer for the device's parallel register port
`timescale 1ns/10ps
module edrs_reg_access (
	input  wire logic                  mclk,
	input  wire logic                  reset_n,
	input  wire logic                  go,
	input  wire edrs_pkg::edrs_acc_req_t req,
	output logic [7:0]                 dev_addr,
	output logic                       dev_cs_n,
	output logic                       dev_rd_n,
	output logic                       dev_wr_n,
	input  wire logic [7:0]            dev_d_in,
	output logic [7:0]                 dev_d_out,
	output logic                       dev_d_oe,
	output logic                       done,
	output logic [7:0]                 rdata
);
	import edrs_pkg::*;

	logic       busy_reg;
	logic [3:0] cnt_reg;

	// Strobes stay low ACC_CYC cycles, data sampled as they rise
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			busy_reg  <= 1'b0;
			cnt_reg   <= 4'h0;
			dev_addr  <= 8'h00;
			dev_cs_n  <= 1'b1;
			dev_rd_n  <= 1'b1;
			dev_wr_n  <= 1'b1;
			dev_d_out <= 8'h00;
			dev_d_oe  <= 1'b0;
			done      <= 1'b0;
			rdata     <= 8'h00;
		end else begin
			done <= 1'b0;
			if (!busy_reg && go) begin
				busy_reg  <= 1'b1;
				cnt_reg   <= ACC_LAST;
				dev_addr  <= req.addr;
				dev_cs_n  <= 1'b0;
				dev_rd_n  <= req.wr;
				dev_wr_n  <= !req.wr;
				dev_d_out <= req.data;
				dev_d_oe  <= req.wr;
			end else if (busy_reg && cnt_reg == 4'h0) begin
				busy_reg <= 1'b0;
				dev_cs_n <= 1'b1;
				dev_rd_n <= 1'b1;
				dev_wr_n <= 1'b1;
				dev_d_oe <= 1'b0;
				done     <= 1'b1;
				rdata    <= dev_d_in;
			end else if (busy_reg) begin
				cnt_reg <= cnt_reg - 4'h1;
			end
		end
	end

endmodule

// ### tb/edrs_dev_model.sv
// Behavioural model of the serial device's DMA support logic
`timescale 1ns/10ps
module edrs_dev_model import edrs_pkg::*; (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  dev_addr,
	input  wire logic        dev_cs_n,
	input  wire logic        dev_rd_n,
	input  wire logic        dev_wr_n,
	input  wire logic [7:0]  dbus,
	output logic [7:0]       dev_q,
	output logic             dev_irq_n,
	output logic             tx_dreq,
	output logic             rx_dreq,
	input  wire logic        tx_dack_n,
	input  wire logic        rx_dack_n,
	input  wire logic [7:0]  dma_bus,
	output logic [7:0]       dma_q,
	input  wire logic        rx_go,
	input  wire logic [11:0] rx_len,
	output logic [7:0]       txh,
	output logic [7:0]       tx_lb,
	output logic [11:0]      rmax,
	output logic [11:0]      rlim,
	output logic [11:0]      rx_tot
);
	logic [7:0]  txl, rml, rll, cyc, blk;
	logic [11:0] tx_left, rx_left, rx_buf;
	logic [3:0]  isr;
	logic        eop, dis, rx_arm, rd_q, wr_q, pause;
	// ************************************************************
	// Decode and requests
	// ************************************************************
	wire        wr_now  = !dev_cs_n && !dev_wr_n;
	wire        wr_new  = wr_now && !wr_q;
	wire        rd_isr  = !dev_cs_n && !dev_rd_n && dev_addr == OFS_ISR;
	wire        tx_byte = !tx_dack_n;
	wire        rx_byte = !rx_dack_n;
	wire        tx_last = tx_byte && tx_left == 12'h001;
	wire        rx_last = rx_byte && rx_left == 12'h001;
	wire        rx_full = rx_byte && !dis && rx_buf + 12'h001 == rmax && !rx_last;
	wire        rx_room = dis || rx_buf != rmax;
	wire [3:0]  ev_set  = {rx_last, rx_full, tx_last && eop, tx_last};
	wire [7:0]  rd_val  = dev_addr == OFS_ISR ? {4'h0, isr} :
		(dev_addr == OFS_RX_BYTE_COUNT_LOW ? rx_tot[7:0] : {4'h0, rx_tot[11:8]});
	assign tx_dreq   = tx_left != 12'h000 && !pause;
	assign rx_dreq   = rx_arm && rx_room && rx_left != 12'h000 && !pause;
	assign dev_irq_n = isr == 4'h0;
	// Released lines show a moving pattern, never the last value
	assign dev_q     = dev_rd_n ? cyc : rd_val;
	assign dma_q     = rx_byte ? rx_tot[7:0] + 8'h40 : ~cyc;
	// Registers load on the first strobe cycle so a later DMA byte is not overwritten
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			{txl, rml, rll, cyc, blk, txh, tx_lb} <= '0;
			{tx_left, rx_left, rx_buf, rmax, rlim, rx_tot} <= '0;
			{isr, eop, dis, rx_arm, rd_q, wr_q, pause} <= '0;
		end else begin
			cyc  <= cyc + 8'h01;
			blk  <= blk + {7'h00, tx_byte || rx_byte};
			pause <= (tx_byte || rx_byte) && blk[4:0] == 5'h1F;
			rd_q <= rd_isr;
			wr_q <= wr_now;
			isr  <= (rd_q && !rd_isr ? 4'h0 : isr) | ev_set;
			if (wr_new && dev_addr == OFS_TXBCL) txl <= dbus;
			if (wr_new && dev_addr == OFS_RMBL) rml <= dbus;
			if (wr_new && dev_addr == OFS_RLLL) rll <= dbus;
			if (wr_new && dev_addr == OFS_RLLH) rlim <= {dbus[3:0], rll};
			if (wr_new && dev_addr == OFS_TXBCH && (dbus[7] || dbus[5])) begin
				tx_left <= {dbus[3:0], txl};
				eop     <= dbus[6];
				txh     <= dbus;
			end else if (tx_byte) begin
				tx_left <= tx_left - 12'h001;
				tx_lb   <= dma_bus;
			end
			if (rx_go) begin
				rx_left <= rx_len;
				rx_tot  <= 12'h000;
			end else if (rx_byte) begin
				rx_left <= rx_left - 12'h001;
				rx_tot  <= rx_tot + 12'h001;
			end
			if (wr_new && dev_addr == OFS_RMBH && dbus[7]) begin
				rmax   <= {dbus[3:0], rml};
				dis    <= dbus[6];
				rx_arm <= 1'b1;
				rx_buf <= 12'h000;
			end else if (rx_last || rx_full) begin
				rx_arm <= 1'b0;
			end else if (rx_byte) begin
				rx_buf <= rx_buf + 12'h001;
			end
		end
	end
endmodule

// ### tb/edrs_host_checker.sv
// Concurrent port checks for the host DMA support controller
`timescale 1ns/10ps
module edrs_host_checker (
	input wire logic       mclk,
	input wire logic       reset_n,
	input wire logic [2:0] avs_address,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest,
	input wire logic       dev_cs_n,
	input wire logic       dev_rd_n,
	input wire logic       dev_wr_n,
	input wire logic       dev_d_oe,
	input wire logic       tx_dreq,
	input wire logic       rx_dreq,
	input wire logic       tx_dack_n,
	input wire logic       rx_dack_n,
	input wire logic       dma_d_oe
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// ************************************************************
	// Register port and DMA link
	// ************************************************************
	// Strobe held two cycles, then a released cycle
	sequence s_strobe;
		!dev_cs_n [*2] ##1 dev_cs_n;
	endsequence
	chk_strobe_len: assert property ($fell(dev_cs_n) |-> s_strobe)
		else $error("register strobe length wrong");
	chk_wr_drive: assert property (!dev_wr_n |-> dev_d_oe && !dev_cs_n)
		else $error("write strobe without bus drive");
	chk_rd_wr_excl: assert property (!(!dev_rd_n && !dev_wr_n))
		else $error("read and write strobes together");
	chk_dack_excl: assert property (!(!tx_dack_n && !rx_dack_n))
		else $error("two acknowledges at once");
	chk_dack_single: assert property (!tx_dack_n || !rx_dack_n |=> tx_dack_n && rx_dack_n)
		else $error("acknowledge longer than one cycle");
	chk_tx_oe: assert property (dma_d_oe == !tx_dack_n)
		else $error("transmit drive not paired with acknowledge");
	// Acknowledge only answers a request seen at the previous edge
	chk_tx_cause: assert property ($fell(tx_dack_n) |-> $past(tx_dreq))
		else $error("transmit acknowledge without request");
	chk_rx_cause: assert property ($fell(rx_dack_n) |-> $past(rx_dreq))
		else $error("receive acknowledge without request");
	chk_avs_answer: assert property ((avs_read || avs_write) && avs_waitrequest
		&& avs_address != 3'h7 |=> !avs_waitrequest)
		else $error("bus access not answered after one wait state");
endmodule
bind edrs_host edrs_host_checker u_chk (
	.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .dev_cs_n(dev_cs_n),
	.dev_rd_n(dev_rd_n), .dev_wr_n(dev_wr_n), .dev_d_oe(dev_d_oe), .tx_dreq(tx_dreq),
	.rx_dreq(rx_dreq), .tx_dack_n(tx_dack_n), .rx_dack_n(rx_dack_n), .dma_d_oe(dma_d_oe)
);

// ### tb/edrs_host_test.sv
// Self-checking bench for the host DMA support controller
`timescale 1ns/10ps
module edrs_host_test;
	import edrs_pkg::*;
	typedef struct {
		logic [11:0] len;
		logic        eop;
		logic        info;
		logic [7:0]  lastb;
	} edrs_row_t;
	logic        mclk, reset_n, avs_read, avs_write, avs_waitrequest, rx_go;
	logic        dev_cs_n, dev_rd_n, dev_wr_n, dev_d_oe, dev_irq_n;
	logic        tx_dreq, rx_dreq, tx_dack_n, rx_dack_n, dma_d_oe;
	logic [2:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [7:0]  dev_addr, dev_d_out, dev_q, dma_d_out, dma_q, txh, tx_lb;
	logic [11:0] rx_len, rmax, rlim, rx_tot;
	int          failures = 0, checked = 0;
	edrs_row_t   rows[4] = '{'{12'h001, 1'b1, 1'b0, 8'h11}, '{12'h005, 1'b0, 1'b0, 8'h22},
		'{12'h003, 1'b1, 1'b1, 8'h33}, '{12'h028, 1'b1, 1'b0, 8'h44}};
	// Shared lines resolve from whoever drives them
	wire [7:0]   dbus    = dev_d_oe ? dev_d_out : dev_q;
	wire [7:0]   dma_bus = dma_d_oe ? dma_d_out : dma_q;
	edrs_host dut (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dev_addr(dev_addr),
		.dev_cs_n(dev_cs_n), .dev_rd_n(dev_rd_n), .dev_wr_n(dev_wr_n), .dev_d_in(dbus),
		.dev_d_out(dev_d_out), .dev_d_oe(dev_d_oe), .dev_irq_n(dev_irq_n), .tx_dreq(tx_dreq),
		.rx_dreq(rx_dreq), .tx_dack_n(tx_dack_n), .rx_dack_n(rx_dack_n), .dma_d_in(dma_bus),
		.dma_d_out(dma_d_out), .dma_d_oe(dma_d_oe));
	edrs_dev_model u_dev (.mclk(mclk), .reset_n(reset_n), .dev_addr(dev_addr),
		.dev_cs_n(dev_cs_n), .dev_rd_n(dev_rd_n), .dev_wr_n(dev_wr_n), .dbus(dbus),
		.dev_q(dev_q), .dev_irq_n(dev_irq_n), .tx_dreq(tx_dreq), .rx_dreq(rx_dreq),
		.tx_dack_n(tx_dack_n), .rx_dack_n(rx_dack_n), .dma_bus(dma_bus), .dma_q(dma_q),
		.rx_go(rx_go), .rx_len(rx_len), .txh(txh), .tx_lb(tx_lb), .rmax(rmax), .rlim(rlim),
		.rx_tot(rx_tot));
	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic finish_test;
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// Request held until waitrequest is seen low at an edge
	task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge mclk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= w;
		avs_read      <= !w;
		do begin @(posedge mclk); n++; end while (avs_waitrequest !== 1'b0 && n < 400);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		if (n >= 400) begin failures++; finish_test; end
	endtask
	task automatic poll(input logic [3:0] m);
		int n = 0;
		do begin av(1'b0, SR_STAT, 32'h0); n++; end while ((q[3:0] & m) !== m && n < 300);
		if (n >= 300) begin failures++; finish_test; end
	endtask
	task automatic pulse(input logic [11:0] len);
		@(posedge mclk);
		rx_go  <= 1'b1;
		rx_len <= len;
		@(posedge mclk);
		rx_go  <= 1'b0;
	endtask
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{reset_n, avs_read, avs_write, rx_go, avs_address, avs_writedata, rx_len} = '0;
		repeat (4) @(posedge mclk);
		reset_n <= 1'b1;
		chk("strobe idle", 32'h1, dev_cs_n);
		chk("wait idle", 32'h1, avs_waitrequest);
		av(1'b0, SR_STAT, 32'h0);
		chk("status reset", 32'h0, q);
		// Transmit rows: last byte preloaded at base plus length less one
		foreach (rows[i]) begin
			av(1'b1, SR_MEM, {16'h0, 8'h0F + rows[i].len[7:0], rows[i].lastb});
			av(1'b1, SR_BASE, 32'h10);
			av(1'b1, SR_TXLEN, {20'h0, rows[i].len});
			av(1'b1, SR_CTRL, {29'h0, rows[i].info, rows[i].eop, 1'b1});
			poll(4'h1);
			chk("tx status", {rows[i].eop, 1'b1}, q[1:0]);
			chk("count high", {!rows[i].info, rows[i].eop, rows[i].info, rows[i].len[11:8]},
				{txh[7:5], txh[3:0]});
			chk("last byte", rows[i].lastb, tx_lb);
			av(1'b1, SR_STAT, 32'hF);
		end
		// Fragmented receive: 40 bytes into 16-byte buffers
		av(1'b1, SR_RXMAX, 32'h10);
		av(1'b1, SR_RXLIM, 32'h64);
		av(1'b1, SR_BASE, 32'h00A0_8000);
		pulse(12'h028);
		av(1'b1, SR_CTRL, 32'h8);
		poll(4'h8);
		chk("rx status", 4'hC, q[3:0]);
		av(1'b0, SR_RXCNT, 32'h0);
		chk("rx count", 12'h028, q[11:0]);
		chk("max size", 12'h010, rmax);
		chk("length limit", 12'h064, rlim);
		av(1'b1, SR_STAT, 32'hF);
		// No requests before re-arm, then limit disabled
		pulse(12'h028);
		repeat (200) @(posedge mclk);
		chk("no rearm", 12'h000, rx_tot);
		av(1'b1, SR_CTRL, 32'h18);
		poll(4'h8);
		chk("no full", 4'h8, q[3:0]);
		chk("moved", 12'h028, rx_tot);
		finish_test;
	end
endmodule
